// >>> common/smc_pkg.sv
// constants and types shared by the sleep controller files
package smc_pkg;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h01;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h07;
	localparam int ARM_BIT = 0;
	localparam int MODE_LSB = 1;
	localparam int MODE_MSB = 2;
	localparam int STAT_ST_LSB = 0;
	localparam int STAT_ST_MSB = 1;
	localparam int STAT_MODE_LSB = 2;
	localparam int STAT_MODE_MSB = 3;
	localparam int STAT_CPU_BIT = 4;
	localparam int WAKE_CYCLES = 6;
	localparam int WAKE_CNT_W = 3;
	localparam logic [WAKE_CNT_W-1:0] WAKE_LAST = WAKE_CNT_W'(WAKE_CYCLES - 1);
	localparam logic [1:0] BOD_WAIT_CFG = 2'h3;

	typedef enum logic [1:0] {
		SMC_IDLE = 2'b00,
		SMC_STBY = 2'b01,
		SMC_POWER_DOWN_MODE = 2'b10,
		SMC_RSVD = 2'b11
	} smc_mode_t;

	typedef enum logic [1:0] {
		SMC_ACTIVE = 2'b00,
		SMC_SLEEP = 2'b01,
		SMC_WAKE_OSC = 2'b10,
		SMC_WAKE_CNT = 2'b11
	} smc_state_t;

	// enabled and pending interrupt requests, one bit per source group
	typedef struct packed {
		logic pin;
		logic twiAddr;
		logic usartSof;
		logic adc;
		logic rtc;
		logic periodic_interrupt_timer;
		logic tcbCap;
		logic voltage_level_monitor;
		logic configurable_logic;
		logic other;
	} smc_wake_t;

	// run_in_standby bits of the peripherals and clock sources
	typedef struct packed {
		logic rtc;
		logic adc;
		logic tcb;
		logic usart;
		logic mainClk;
		logic rtcClk;
	} smc_run_in_standby_t;

	// clock domain and oscillator enables, high = running
	typedef struct packed {
		logic cpu;
		logic per;
		logic rtc;
		logic periodic_interrupt_timer;
		logic adc;
		logic tcb;
		logic usart;
		logic brownout_detector;
		logic wdt;
		logic mainOsc;
		logic rtcOsc;
		logic ulpOsc;
	} smc_gate_t;

endpackage : smc_pkg

// >>> logic/smc_wake_timer.sv
// wake-up cycle counter of the sleep controller
`timescale 1ns/10ps
`default_nettype none

module smc_wake_timer (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic run,
	output logic done
);

	logic [smc_pkg::WAKE_CNT_W-1:0] cnt;
	logic [smc_pkg::WAKE_CNT_W-1:0] next_cnt;

	// saturates at the last count so a slow brown-out ready can extend the wait
	always_comb begin
		next_cnt = cnt;
		if (!run) begin
			next_cnt = '0;
		end else if (cnt != smc_pkg::WAKE_LAST) begin
			next_cnt = cnt + smc_pkg::WAKE_CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
		end else if (clkEn) begin
			cnt <= next_cnt;
		end
	end

	assign done = run && (cnt == smc_pkg::WAKE_LAST);

endmodule : smc_wake_timer

`default_nettype wire

// >>> logic/smc_sleep_controller.sv
// sleep controller: mode register, sleep/wake sequencing and clock gating
// Notes on behaviour
// - sleep is entered only on the sleep instruction with the arm bit set
// - with no enabled interrupt the device stays asleep until reset or a debug break
// - idle stops only the cpu clock; any interrupt wakes
// - standby keeps rtc, adc, timer_b, main and rtc clock only with run_in_standby
// - standby: pin and two_wire wake always; usart, adc, rtc, periodic timer, timer_b only with run_in_standby; others never
// - adc may keep converting in standby without waking the cpu
// - power_down keeps brownout, watchdog, periodic timer; five wake groups
// - power_down stops all oscillators but ulp and rtc clock when needed
// - wake takes six cycles, plus oscillator start in standby and power_down
// - idle keeps the main oscillator running, no start-up wait
// - brownout setting 0x3 holds wake until the detector is ready
// - a debug break wakes the device back to active
// - a wake interrupt resumes the cpu; any reset ends sleep
// - mode field: idle 0x0, standby 0x1, power_down 0x2, 0x3 reserved
`timescale 1ns/10ps
`default_nettype none

module smc_sleep_controller (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	input wire logic sleepInstr,
	input wire logic irqGlobalEn,
	input wire smc_pkg::smc_wake_t wakeIn,
	input wire smc_pkg::smc_run_in_standby_t run_in_standby,
	input wire logic bodUsesOsc,
	input wire logic wdtUsesOsc,
	input wire logic mainOscReady,
	input wire logic [1:0] bodActiveCfg,
	input wire logic bodReady,
	input wire logic debugBreak,
	output smc_pkg::smc_gate_t gate,
	output logic cpuRun
);

	logic [7:0] ctl;
	logic [7:0] next_ctl;
	logic [7:0] next_regRdata;
	smc_pkg::smc_state_t st;
	smc_pkg::smc_state_t next_st;
	smc_pkg::smc_mode_t mode;
	smc_pkg::smc_mode_t next_mode;
	smc_pkg::smc_mode_t ctlMode;
	smc_pkg::smc_wake_t allow;
	logic wakeReq;
	logic bodOk;
	logic cntDone;
	logic sleepEntry;
	logic oscKeep;

	assign ctlMode = smc_pkg::smc_mode_t'(ctl[smc_pkg::MODE_MSB:smc_pkg::MODE_LSB]);
	assign sleepEntry = sleepInstr && ctl[smc_pkg::ARM_BIT];
	assign bodOk = (bodActiveCfg != smc_pkg::BOD_WAIT_CFG) || bodReady;
	assign oscKeep = bodUsesOsc || wdtUsesOsc;

	// wake sources allowed by the latched mode
	always_comb begin
		allow = '0;
		unique case (mode)
			smc_pkg::SMC_IDLE, smc_pkg::SMC_RSVD: begin
				allow = '1;
			end
			smc_pkg::SMC_STBY: begin
				allow.pin = 1'b1;
				allow.twiAddr = 1'b1;
				allow.usartSof = run_in_standby.usart;
				allow.adc = run_in_standby.adc;
				allow.rtc = run_in_standby.rtc;
				allow.periodic_interrupt_timer = run_in_standby.rtc;
				allow.tcbCap = run_in_standby.tcb;
			end
			smc_pkg::SMC_POWER_DOWN_MODE: begin
				allow.pin = 1'b1;
				allow.periodic_interrupt_timer = 1'b1;
				allow.voltage_level_monitor = 1'b1;
				allow.twiAddr = 1'b1;
				allow.configurable_logic = 1'b1;
			end
		endcase
	end

	// without global interrupt enable only a debug break or reset can end sleep
	assign wakeReq = debugBreak || (irqGlobalEn && (|(wakeIn & allow)));

	// register port and sleep sequencer
	always_comb begin
		next_ctl = ctl;
		next_regRdata = '0;
		next_st = st;
		next_mode = mode;
		if (regWr && (regAddr == smc_pkg::ADDR_CTRL)) begin
			next_ctl = regWdata & smc_pkg::CTRL_WMASK;
		end
		if (regRd && (regAddr == smc_pkg::ADDR_CTRL)) begin
			next_regRdata = ctl;
		end else if (regRd && (regAddr == smc_pkg::ADDR_STAT)) begin
			next_regRdata[smc_pkg::STAT_ST_MSB:smc_pkg::STAT_ST_LSB] = st;
			next_regRdata[smc_pkg::STAT_MODE_MSB:smc_pkg::STAT_MODE_LSB] = mode;
			next_regRdata[smc_pkg::STAT_CPU_BIT] = cpuRun;
		end
		unique case (st)
			smc_pkg::SMC_ACTIVE: begin
				if (sleepEntry) begin
					next_st = smc_pkg::SMC_SLEEP;
					// a reserved code sleeps as idle so the part stays recoverable
					next_mode = (ctlMode == smc_pkg::SMC_RSVD) ? smc_pkg::SMC_IDLE : ctlMode;
				end
			end
			smc_pkg::SMC_SLEEP: begin
				if (wakeReq) begin
					// idle never stops the main oscillator, so skip its start wait
					if (mode == smc_pkg::SMC_IDLE) begin
						next_st = smc_pkg::SMC_WAKE_CNT;
					end else begin
						next_st = smc_pkg::SMC_WAKE_OSC;
					end
				end
			end
			smc_pkg::SMC_WAKE_OSC: begin
				if (mainOscReady) begin
					next_st = smc_pkg::SMC_WAKE_CNT;
				end
			end
			smc_pkg::SMC_WAKE_CNT: begin
				if (cntDone && bodOk) begin
					next_st = smc_pkg::SMC_ACTIVE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctl <= smc_pkg::CTRL_RESET;
			regRdata <= '0;
			st <= smc_pkg::SMC_ACTIVE;
			mode <= smc_pkg::SMC_IDLE;
		end else if (clkEn) begin
			ctl <= next_ctl;
			regRdata <= next_regRdata;
			st <= next_st;
			mode <= next_mode;
		end
	end

	smc_wake_timer u_timer (
		.core_clk(core_clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.run(st == smc_pkg::SMC_WAKE_CNT),
		.done(cntDone)
	);

	// clock domain and oscillator enables
	always_comb begin
		gate = '1;
		gate.cpu = (st == smc_pkg::SMC_ACTIVE);
		if (st == smc_pkg::SMC_SLEEP) begin
			unique case (mode)
				smc_pkg::SMC_IDLE, smc_pkg::SMC_RSVD: begin
				end
				smc_pkg::SMC_STBY: begin
					gate.per = 1'b0;
					gate.rtc = run_in_standby.rtc;
					gate.periodic_interrupt_timer = run_in_standby.rtc;
					gate.adc = run_in_standby.adc;
					gate.tcb = run_in_standby.tcb;
					gate.usart = run_in_standby.usart;
					gate.mainOsc = run_in_standby.mainClk;
					gate.rtcOsc = run_in_standby.rtcClk;
				end
				smc_pkg::SMC_POWER_DOWN_MODE: begin
					gate = '0;
					gate.brownout_detector = 1'b1;
					gate.wdt = 1'b1;
					gate.periodic_interrupt_timer = 1'b1;
					gate.ulpOsc = oscKeep;
					gate.rtcOsc = oscKeep;
				end
			endcase
		end
	end

	assign cpuRun = gate.cpu;

	property p_noSleepWithoutInstr;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_ACTIVE) && !sleepEntry |=> (st != smc_pkg::SMC_SLEEP);
	endproperty
	a_noSleepWithoutInstr: assert property (p_noSleepWithoutInstr) else $error("sleep without instruction");

	property p_idleGates;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && (mode == smc_pkg::SMC_IDLE) |-> !cpuRun && gate.per && gate.mainOsc;
	endproperty
	a_idleGates: assert property (p_idleGates) else $error("idle gating wrong");

	property p_stbyGates;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && (mode == smc_pkg::SMC_STBY)
		|-> !gate.per && (gate.adc == run_in_standby.adc) && (gate.mainOsc == run_in_standby.mainClk);
	endproperty
	a_stbyGates: assert property (p_stbyGates) else $error("standby gating wrong");

	property p_stbyPinWake;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && (mode == smc_pkg::SMC_STBY) && wakeIn.pin && irqGlobalEn && clkEn
		|=> (st == smc_pkg::SMC_WAKE_OSC);
	endproperty
	a_stbyPinWake: assert property (p_stbyPinWake) else $error("standby pin wake missed");

	property p_pdownWakeSet;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && (mode == smc_pkg::SMC_POWER_DOWN_MODE) && !debugBreak
		&& !(wakeIn.pin || wakeIn.periodic_interrupt_timer || wakeIn.voltage_level_monitor || wakeIn.twiAddr || wakeIn.configurable_logic)
		|=> (st == smc_pkg::SMC_SLEEP);
	endproperty
	a_pdownWakeSet: assert property (p_pdownWakeSet) else $error("power_down woke on wrong source");

	property p_pdownOsc;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && (mode == smc_pkg::SMC_POWER_DOWN_MODE)
		|-> !gate.mainOsc && (gate.ulpOsc == (bodUsesOsc || wdtUsesOsc));
	endproperty
	a_pdownOsc: assert property (p_pdownOsc) else $error("power_down oscillator wrong");

	property p_sixCycles;
		@(posedge core_clk) disable iff (!resetn)
		$rose(st == smc_pkg::SMC_WAKE_CNT) ##0 (clkEn && bodOk)[*6] |-> !cpuRun ##1 cpuRun;
	endproperty
	a_sixCycles: assert property (p_sixCycles) else $error("wake count not six");

	property p_idleNoOsc;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && (mode == smc_pkg::SMC_IDLE) && wakeReq && clkEn
		|=> (st == smc_pkg::SMC_WAKE_CNT);
	endproperty
	a_idleNoOsc: assert property (p_idleNoOsc) else $error("idle waited for oscillator");

	property p_bodHold;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_WAKE_CNT) && (bodActiveCfg == smc_pkg::BOD_WAIT_CFG) && !bodReady |=> !cpuRun;
	endproperty
	a_bodHold: assert property (p_bodHold) else $error("ran before brownout ready");

	property p_debugWake;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && debugBreak && clkEn |=> (st != smc_pkg::SMC_SLEEP);
	endproperty
	a_debugWake: assert property (p_debugWake) else $error("debug break ignored");

	property p_noIrqStay;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && !irqGlobalEn && !debugBreak |=> (st == smc_pkg::SMC_SLEEP);
	endproperty
	a_noIrqStay: assert property (p_noIrqStay) else $error("woke without interrupts");

	property p_rsvdIdle;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_ACTIVE) && sleepEntry && clkEn && (ctlMode == smc_pkg::SMC_RSVD)
		|=> (mode == smc_pkg::SMC_IDLE);
	endproperty
	a_rsvdIdle: assert property (p_rsvdIdle) else $error("reserved mode not idle");

	property p_armRequired;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_ACTIVE) && sleepInstr && !ctl[smc_pkg::ARM_BIT] |=> (st == smc_pkg::SMC_ACTIVE);
	endproperty
	a_armRequired: assert property (p_armRequired) else $error("slept with arm bit clear");

	// the main oscillator is requested again as soon as wake-up starts
	property p_wakeOscOn;
		@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_WAKE_OSC) || (st == smc_pkg::SMC_WAKE_CNT) |-> !cpuRun && gate.mainOsc && gate.per;
	endproperty
	a_wakeOscOn: assert property (p_wakeOscOn) else $error("wake without main oscillator");

	// no disable here, so the reset picture itself is watched
	property p_resetActive;
		@(posedge core_clk)
		!resetn |=> cpuRun && (st == smc_pkg::SMC_ACTIVE);
	endproperty
	a_resetActive: assert property (p_resetActive) else $error("reset did not end sleep");

	c_stbySleep: cover property (@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_SLEEP) && (mode == smc_pkg::SMC_STBY));
	c_pdownWake: cover property (@(posedge core_clk) disable iff (!resetn)
		(st == smc_pkg::SMC_WAKE_OSC) && (mode == smc_pkg::SMC_POWER_DOWN_MODE) ##[1:50] cpuRun);
	c_bodExtend: cover property (@(posedge core_clk) disable iff (!resetn)
		cntDone && !bodOk);

endmodule : smc_sleep_controller

`default_nettype wire

// >>> test/smc_osc_model.sv
// main oscillator start-up model facing the sleep controller
`timescale 1ns/10ps
`default_nettype none

module smc_osc_model #(
	parameter int START = 4
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic oscOn,
	output logic oscReady
);
	int count;

	// every restart pays the full start-up, so a gated-off oscillator is never ready at once
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count <= START;
		end else if (!oscOn) begin
			count <= 0;
		end else if (count < START) begin
			count <= count + 1;
		end
	end

	assign oscReady = (count >= START);
endmodule : smc_osc_model
`default_nettype wire

// >>> test/smc_sleep_controller_tb.sv
// self-checking bench of the sleep controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin totalChecks++; if ((got) !== (exp)) begin fails++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end

module smc_sleep_controller_tb;
	localparam int OSC = 4;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic clkEn = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdata;
	logic sleepInstr = 1'b0;
	logic irqGlobalEn = 1'b0;
	smc_pkg::smc_wake_t wakeIn = '0;
	smc_pkg::smc_run_in_standby_t run_in_standby = '0;
	logic bodUsesOsc = 1'b0;
	logic wdtUsesOsc = 1'b0;
	logic mainOscReady;
	logic [1:0] bodActiveCfg = 2'h0;
	logic bodReady = 1'b1;
	logic debugBreak = 1'b0;
	smc_pkg::smc_gate_t gate;
	logic cpuRun;
	int fails = 0;
	int totalChecks = 0;
	int cycles = 0;
	logic [7:0] rd;
	logic [1:0] m;
	smc_pkg::smc_wake_t w;
	logic ext;
	int lo;
	int hi;

	smc_sleep_controller smc_sleep_controller_inst (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.sleepInstr(sleepInstr), .irqGlobalEn(irqGlobalEn), .wakeIn(wakeIn), .run_in_standby(run_in_standby),
		.bodUsesOsc(bodUsesOsc), .wdtUsesOsc(wdtUsesOsc), .mainOscReady(mainOscReady),
		.bodActiveCfg(bodActiveCfg), .bodReady(bodReady), .debugBreak(debugBreak), .gate(gate), .cpuRun(cpuRun));

	smc_osc_model #(.START(OSC)) smc_osc_model_inst (.core_clk(core_clk), .resetn(resetn),
		.oscOn(gate.mainOsc), .oscReady(mainOscReady));

	always #25 core_clk = ~core_clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	// ceiling is about five times the expected run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			$display("MISMATCH t=%0t timeout", $time);
			stop_test();
		end
	end

	task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : regWrite

	task automatic regRead(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask : regRead

	// reserved mode falls through to the idle picture
	function automatic logic [11:0] expGate(input logic [1:0] md, input smc_pkg::smc_run_in_standby_t r, input logic u);
		if (md == 2'h1) return {2'b00, r.rtc, r.rtc, r.adc, r.tcb, r.usart, 2'b11, r.mainClk, r.rtcClk, 1'b1};
		if (md == 2'h2) return {3'b000, 1'b1, 3'b000, 2'b11, 1'b0, u, u};
		return 12'h7FF;
	endfunction : expGate

	function automatic logic allowed(input logic [1:0] md, input smc_pkg::smc_wake_t x, input smc_pkg::smc_run_in_standby_t r);
		if (md == 2'h1) return x.pin | x.twiAddr | (x.usartSof & r.usart) | (x.adc & r.adc)
			| ((x.rtc | x.periodic_interrupt_timer) & r.rtc) | (x.tcbCap & r.tcb);
		if (md == 2'h2) return x.pin | x.periodic_interrupt_timer | x.voltage_level_monitor | x.twiAddr | x.configurable_logic;
		return |x;
	endfunction : allowed

	task automatic sleepEnter(input logic [1:0] md);
		logic [7:0] es;
		regWrite(smc_pkg::ADDR_CTRL, {5'h00, md, 1'b1});
		@(posedge core_clk);
		sleepInstr <= 1'b1;
		@(posedge core_clk);
		sleepInstr <= 1'b0;
		#1;
		`CHK(cpuRun, 1'b0)
		`CHK(gate, expGate(md, run_in_standby, bodUsesOsc | wdtUsesOsc))
		// status: sleeping, latched mode with reserved shown as idle, cpu stopped
		es = {4'h0, ((md == 2'h3) ? 2'h0 : md), 2'h1};
		regRead(smc_pkg::ADDR_STAT, rd);
		`CHK(rd, es)
	endtask : sleepEnter

	// counts edges from the one that first samples the wake cause
	task automatic waitWake(input int l, input int h, input logic slowBod);
		int n;
		n = 0;
		while (n < 40) begin
			@(posedge core_clk);
			n++;
			if (slowBod && n == 9) bodReady <= 1'b1;
			#1;
			if (cpuRun === 1'b1) break;
		end
		`CHK(n >= l && n <= h, 1'b1)
	endtask : waitWake

	initial begin
		void'($urandom(32'hCFADCD9A));
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		regRead(smc_pkg::ADDR_CTRL, rd);
		`CHK(rd, smc_pkg::CTRL_RESET)
		regRead(smc_pkg::ADDR_STAT, rd);
		`CHK(rd, 8'h10)
		regWrite(smc_pkg::ADDR_CTRL, 8'hFF);
		regRead(smc_pkg::ADDR_CTRL, rd);
		`CHK(rd, 8'h07)
		regRead(8'h05, rd);
		`CHK(rd, 8'h00)
		regWrite(smc_pkg::ADDR_CTRL, 8'h04);
		@(posedge core_clk);
		sleepInstr <= 1'b1;
		@(posedge core_clk);
		sleepInstr <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(cpuRun, 1'b1)
		// a write while the clock enable is low must be lost
		@(posedge core_clk);
		clkEn <= 1'b0;
		regWrite(smc_pkg::ADDR_CTRL, 8'h03);
		clkEn <= 1'b1;
		regRead(smc_pkg::ADDR_CTRL, rd);
		`CHK(rd, 8'h04)
		for (int i = 0; i < 32; i++) begin
			m = 2'(i % 4);
			w = smc_pkg::smc_wake_t'(10'h001 << ($urandom % 10));
			ext = ($urandom % 2) == 1;
			@(posedge core_clk);
			run_in_standby <= 6'($urandom);
			bodUsesOsc <= 1'($urandom);
			wdtUsesOsc <= 1'($urandom);
			bodActiveCfg <= 2'($urandom);
			irqGlobalEn <= ($urandom % 4) != 0;
			sleepEnter(m);
			ext = ext && bodActiveCfg == smc_pkg::BOD_WAIT_CFG;
			lo = ext ? 10 : 7;
			hi = (m == 2'h0 || m == 2'h3) ? (ext ? 11 : 7) : lo + OSC + 3;
			@(posedge core_clk);
			wakeIn <= w;
			if (ext) bodReady <= 1'b0;
			if (!(allowed(m, w, run_in_standby) && irqGlobalEn)) begin
				repeat (15) @(posedge core_clk);
				#1;
				`CHK(cpuRun, 1'b0)
				@(posedge core_clk);
				debugBreak <= 1'b1;
			end
			waitWake(lo, hi, ext);
			@(posedge core_clk);
			wakeIn <= '0;
			debugBreak <= 1'b0;
			bodReady <= 1'b1;
			$display("test %0d mode %0d done", i, m);
		end
		irqGlobalEn <= 1'b0;
		sleepEnter(2'h2);
		@(posedge core_clk);
		wakeIn <= '1;
		repeat (20) @(posedge core_clk);
		#1;
		`CHK(cpuRun, 1'b0)
		@(posedge core_clk);
		resetn <= 1'b0;
		#1;
		`CHK(cpuRun, 1'b1)
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		wakeIn <= '0;
		regRead(smc_pkg::ADDR_CTRL, rd);
		`CHK(rd, smc_pkg::CTRL_RESET)
		$display("test reset during sleep done");
		stop_test();
	end
endmodule : smc_sleep_controller_tb
`default_nettype wire
